//--- src/ast_uart.sv
// asynchronous serial transceiver with fifos, flow control and diagnostics
`timescale 1ns/1ns
// Behaviour
// - shift rx bits in, tx words out
// - bit timing from divisor 1 to 65535
// - five to eight data bits selectable
// - even, odd or no parity generated/checked
// - stop of one, one and a half, two bits
// - separate sixteen byte tx and rx fifos
// - fifos disabled means single holding stage
// - rx trigger 1/4/8/14 drives rts, dma
// - dma requests for rx data, tx space
// - interrupts for rx data and tx space
// - short low glitch rejected as start
// - break send on command and detect
// - loopback routes tx back into rx
// - force break, parity, overrun, framing errors
// - autoflow: rts drops at trigger, cts pauses
// - bit period at least sixteen clocks
// - start and data bits last one period
module ast_uart
  import ast_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic [4:0]  ADDR_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [15:0] RDATA_OUT,
  input  wire logic        RXD_IN,
  output logic             TXD_OUT,
  input  wire logic        CTS_N_IN,
  output logic             RTS_N_OUT,
  output logic             RX_DMA_REQ_OUT,
  output logic             TX_DMA_REQ_OUT,
  output logic             RX_INT_OUT,
  output logic             TX_INT_OUT
);
  localparam logic [4:0] CAP_FULL = 5'(DEPTH);

  function automatic logic [7:0] len_mask(input logic [1:0] len);
    len_mask = 8'hFF >> (2'h3 - len);
  endfunction

  function automatic logic par_of(input logic [7:0] d, input logic [1:0] len, input logic even);
    par_of = (^(d & len_mask(len))) ^ ~even;
  endfunction

  function automatic logic is_full(input logic [4:0] cnt, input logic fen);
    is_full = fen ? (cnt >= CAP_FULL) : (cnt != 5'h00);
  endfunction

  logic [13:0] ctrl;
  logic [15:0] div;
  logic [15:0] div_cnt;
  logic        s_ovr;
  logic        s_par;
  logic        s_frm;
  logic        s_brk;
  logic [7:0]  tx_mem [DEPTH];
  logic [7:0]  rx_mem [DEPTH];
  logic [3:0]  tx_wp;
  logic [3:0]  tx_rp;
  logic [4:0]  tx_cnt;
  logic [3:0]  rx_wp;
  logic [3:0]  rx_rp;
  logic [4:0]  rx_cnt;
  ast_tx_type  tx_st;
  ast_rx_type  rx_st;
  logic [5:0]  tx_sub;
  logic [2:0]  tx_bit;
  logic [7:0]  tx_shift;
  logic        tx_par;
  logic        tx_line;
  logic [5:0]  rx_sub;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_shift;
  logic        rx_pbit;

  wire         fen       = ctrl[C_FEN];
  wire  [1:0]  len       = ctrl[C_LEN+:2];
  wire         pen       = ctrl[C_PEN];
  wire         afc       = ctrl[C_AFC];
  wire  [15:0] div_eff   = (div == 16'h0000) ? 16'h0001 : div;
  wire         tick      = (div_cnt >= div_eff - 16'h0001);
  wire         wr_data   = WR_IN && (ADDR_IN == ADDR_DATA);
  wire         wr_force  = WR_IN && (ADDR_IN == ADDR_FORCE);
  wire         rd_data   = RD_IN && (ADDR_IN == ADDR_DATA);
  wire         rd_stat   = RD_IN && (ADDR_IN == ADDR_STAT);
  wire         tx_full   = is_full(tx_cnt, fen);
  wire         rx_full   = is_full(rx_cnt, fen);
  wire         tx_push   = wr_data && !tx_full;
  wire         cts_ok    = !afc || !CTS_N_IN;
  wire         tx_pop    = (tx_st == TX_IDLE) && (tx_cnt != 5'h00) && cts_ok;
  wire         rx_pop    = rd_data && (rx_cnt != 5'h00);
  wire  [4:0]  trig_lvl  = !fen ? TRIG_1 :
                           (ctrl[C_TRIG+:2] == 2'h0) ? TRIG_1 :
                           (ctrl[C_TRIG+:2] == 2'h1) ? TRIG_4 :
                           (ctrl[C_TRIG+:2] == 2'h2) ? TRIG_8 : TRIG_14;
  wire         rx_trig   = (rx_cnt >= trig_lvl);
  wire  [5:0]  stop_len  = (ctrl[C_STOP+:2] == 2'h1) ? STOP_1P5 :
                           (ctrl[C_STOP+:2] == 2'h2) ? STOP_2 : OVS_TICKS;
  wire         rx_line   = ctrl[C_LOOP] ? (tx_line && !ctrl[C_BRK]) : RXD_IN;
  wire         bit_end   = tick && (rx_sub == OVS_TICKS - 6'h01);
  wire         rx_done   = (rx_st == RX_STOP) && bit_end;
  wire  [7:0]  rx_word   = rx_shift >> (2'h3 - len);
  wire         rx_perr   = pen && (rx_pbit != par_of(rx_word, len, ctrl[C_EVEN]));
  wire         rx_isbrk  = (rx_word == 8'h00) && !rx_line && !(pen && rx_pbit);
  wire         rx_push   = rx_done && !rx_full;
  wire         set_ovr   = (rx_done && rx_full) || (wr_force && WDATA_IN[F_OVR]);
  wire         set_par   = (rx_done && rx_perr) || (wr_force && WDATA_IN[F_PAR]);
  wire         set_frm   = (rx_done && !rx_line) || (wr_force && WDATA_IN[F_FRM]);
  wire         set_brk   = (rx_done && rx_isbrk) || (wr_force && WDATA_IN[F_BRK]);
  wire  [15:0] stat_word = {9'h000, (tx_cnt == 5'h00) && (tx_st == TX_IDLE), s_brk, s_frm, s_par, s_ovr,
                            !tx_full, rx_cnt != 5'h00};
  wire  [15:0] rd_mux    = (ADDR_IN == ADDR_DATA) ? {8'h00, rx_mem[rx_rp]} :
                           (ADDR_IN == ADDR_CTRL) ? {2'h0, ctrl} :
                           (ADDR_IN == ADDR_DIV)  ? div :
                           (ADDR_IN == ADDR_STAT) ? stat_word : 16'h0000;

  // register port and sticky status, set wins over read clear
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ctrl      <= CTRL_RST;
      div       <= DIV_RST;
      RDATA_OUT <= 16'h0000;
      s_ovr     <= 1'b0;
      s_par     <= 1'b0;
      s_frm     <= 1'b0;
      s_brk     <= 1'b0;
    end else begin
      if (WR_IN && ADDR_IN == ADDR_CTRL) ctrl <= WDATA_IN[13:0];
      if (WR_IN && ADDR_IN == ADDR_DIV) div <= WDATA_IN;
      if (RD_IN) RDATA_OUT <= rd_mux;
      s_ovr <= set_ovr || (s_ovr && !rd_stat);
      s_par <= set_par || (s_par && !rd_stat);
      s_frm <= set_frm || (s_frm && !rd_stat);
      s_brk <= set_brk || (s_brk && !rd_stat);
    end
  end

  // sixteen-times oversampling tick
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  // transmit fifo, single stage when fifos are off
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_wp  <= 4'h0;
      tx_rp  <= 4'h0;
      tx_cnt <= 5'h00;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 4'h1;
      if (tx_pop) tx_rp <= tx_rp + 4'h1;
      tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (tx_push) tx_mem[tx_wp] <= WDATA_IN[7:0];
    if (rx_push) rx_mem[rx_wp] <= rx_word & len_mask(len);
  end

  // receive fifo, overrun drops the new character
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_wp  <= 4'h0;
      rx_rp  <= 4'h0;
      rx_cnt <= 5'h00;
    end else begin
      if (rx_push) rx_wp <= rx_wp + 4'h1;
      if (rx_pop) rx_rp <= rx_rp + 4'h1;
      rx_cnt <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  // transmitter: start, data lsb first, parity, stop
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_st    <= TX_IDLE;
      tx_sub   <= 6'h00;
      tx_bit   <= 3'h0;
      tx_shift <= 8'h00;
      tx_par   <= 1'b0;
      tx_line  <= 1'b1;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_pop) begin
            tx_shift <= tx_mem[tx_rp];
            tx_par   <= par_of(tx_mem[tx_rp], len, ctrl[C_EVEN]);
            tx_sub   <= 6'h00;
            tx_line  <= 1'b0;
            tx_st    <= TX_START;
          end
        end
        TX_START: begin
          if (tick) begin
            tx_sub <= tx_sub + 6'h01;
            if (tx_sub == OVS_TICKS - 6'h01) begin
              tx_sub   <= 6'h00;
              tx_bit   <= 3'h0;
              tx_line  <= tx_shift[0];
              tx_shift <= tx_shift >> 1;
              tx_st    <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (tick) begin
            tx_sub <= tx_sub + 6'h01;
            if (tx_sub == OVS_TICKS - 6'h01) begin
              tx_sub <= 6'h00;
              tx_bit <= tx_bit + 3'h1;
              if (tx_bit == {1'b1, len}) begin
                tx_line <= pen ? tx_par : 1'b1;
                tx_st   <= pen ? TX_PAR : TX_STOP;
              end else begin
                tx_line  <= tx_shift[0];
                tx_shift <= tx_shift >> 1;
              end
            end
          end
        end
        TX_PAR: begin
          if (tick) begin
            tx_sub <= tx_sub + 6'h01;
            if (tx_sub == OVS_TICKS - 6'h01) begin
              tx_sub  <= 6'h00;
              tx_line <= 1'b1;
              tx_st   <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (tick) begin
            tx_sub <= tx_sub + 6'h01;
            if (tx_sub == stop_len - 6'h01) begin
              tx_sub <= 6'h00;
              tx_st  <= TX_IDLE;
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // receiver: start qualified at half bit, then centre samples
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_st    <= RX_IDLE;
      rx_sub   <= 6'h00;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
      rx_pbit  <= 1'b0;
    end else begin
      case (rx_st)
        RX_IDLE: begin
          rx_sub <= 6'h00;
          if (tick && !rx_line) rx_st <= RX_START;
        end
        RX_START: begin
          if (tick) begin
            rx_sub <= rx_sub + 6'h01;
            if (rx_sub == HALF_TICKS - 6'h01) begin
              rx_sub <= 6'h00;
              rx_bit <= 3'h0;
              rx_st  <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) rx_sub <= rx_sub + 6'h01;
          if (bit_end) begin
            rx_sub   <= 6'h00;
            rx_bit   <= rx_bit + 3'h1;
            rx_shift <= {rx_line, rx_shift[7:1]};
            if (rx_bit == {1'b1, len}) rx_st <= pen ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (tick) rx_sub <= rx_sub + 6'h01;
          if (bit_end) begin
            rx_sub  <= 6'h00;
            rx_pbit <= rx_line;
            rx_st   <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (tick) rx_sub <= rx_sub + 6'h01;
          if (bit_end) begin
            rx_sub <= 6'h00;
            rx_st  <= rx_line ? RX_IDLE : RX_WAIT;
          end
        end
        RX_WAIT: begin
          if (rx_line) rx_st <= RX_IDLE;
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // registered line, flow control, dma and interrupt outputs
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      TXD_OUT        <= 1'b1;
      RTS_N_OUT      <= 1'b0;
      RX_DMA_REQ_OUT <= 1'b0;
      TX_DMA_REQ_OUT <= 1'b0;
      RX_INT_OUT     <= 1'b0;
      TX_INT_OUT     <= 1'b0;
    end else begin
      TXD_OUT        <= ctrl[C_LOOP] ? 1'b1 : (tx_line && !ctrl[C_BRK]);
      RTS_N_OUT      <= afc && rx_trig;
      RX_DMA_REQ_OUT <= rx_trig;
      TX_DMA_REQ_OUT <= !tx_full;
      RX_INT_OUT     <= ctrl[C_RXIE] && rx_trig;
      TX_INT_OUT     <= ctrl[C_TXIE] && !tx_full;
    end
  end
endmodule // ast_uart

//--- src/ast_pkg.sv
// shared constants and types of the asynchronous serial transceiver
package ast_pkg;
  localparam logic [4:0]  ADDR_DATA  = 5'h00;
  localparam logic [4:0]  ADDR_CTRL  = 5'h04;
  localparam logic [4:0]  ADDR_DIV   = 5'h08;
  localparam logic [4:0]  ADDR_STAT  = 5'h0C;
  localparam logic [4:0]  ADDR_FORCE = 5'h10;
  localparam int          C_LEN      = 0;
  localparam int          C_PEN      = 2;
  localparam int          C_EVEN     = 3;
  localparam int          C_STOP     = 4;
  localparam int          C_FEN      = 6;
  localparam int          C_TRIG     = 7;
  localparam int          C_BRK      = 9;
  localparam int          C_LOOP     = 10;
  localparam int          C_AFC      = 11;
  localparam int          C_RXIE     = 12;
  localparam int          C_TXIE     = 13;
  localparam logic [13:0] CTRL_RST   = 14'h0043;
  localparam logic [15:0] DIV_RST    = 16'h0001;
  localparam int          S_RXAV     = 0;
  localparam int          S_TXRDY    = 1;
  localparam int          S_OVR      = 2;
  localparam int          S_PAR      = 3;
  localparam int          S_FRM      = 4;
  localparam int          S_BRK      = 5;
  localparam int          S_TXMT     = 6;
  localparam int          F_BRK      = 0;
  localparam int          F_PAR      = 1;
  localparam int          F_OVR      = 2;
  localparam int          F_FRM      = 3;
  localparam logic [5:0]  OVS_TICKS  = 6'h10;
  localparam logic [5:0]  HALF_TICKS = 6'h08;
  localparam logic [5:0]  STOP_1P5   = 6'h18;
  localparam logic [5:0]  STOP_2     = 6'h20;
  localparam logic [4:0]  TRIG_1     = 5'h01;
  localparam logic [4:0]  TRIG_4     = 5'h04;
  localparam logic [4:0]  TRIG_8     = 5'h08;
  localparam logic [4:0]  TRIG_14    = 5'h0E;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ast_tx_type;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} ast_rx_type;
endpackage

//--- verification/ast_uart_properties.sv
// port checker for the serial transceiver
`timescale 1ns/1ns
module ast_uart_props
  import ast_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic        REF_CLK_IN,
  input wire logic        NRST_IN,
  input wire logic [4:0]  ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic        RXD_IN,
  input wire logic        TXD_OUT,
  input wire logic        CTS_N_IN,
  input wire logic        RTS_N_OUT,
  input wire logic        RX_DMA_REQ_OUT,
  input wire logic        TX_DMA_REQ_OUT,
  input wire logic        RX_INT_OUT,
  input wire logic        TX_INT_OUT
);
  logic [5:0] lo_run, hi_run, acc_age;
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      lo_run <= 6'h00;
      hi_run <= 6'h3F;
      acc_age <= 6'h3F;
    end else begin
      lo_run <= TXD_OUT ? 6'h00 : lo_run + 6'(lo_run != 6'h3F);
      hi_run <= TXD_OUT ? hi_run + 6'(hi_run != 6'h3F) : 6'h00;
      acc_age <= (RD_IN || WR_IN) ? 6'h00 : acc_age + 6'(acc_age != 6'h3F);
    end
  end
  property p_low_len; $rose(TXD_OUT) |-> lo_run >= 6'h10; endproperty
  a_low_len: assert property (p_low_len) else $error("short low bit");
  property p_stop_len; $fell(TXD_OUT) |-> hi_run >= 6'h10; endproperty
  a_stop_len: assert property (p_stop_len) else $error("short stop");
  property p_txint; TX_INT_OUT |-> TX_DMA_REQ_OUT; endproperty
  a_txint: assert property (p_txint) else $error("tx irq when full");
  property p_rxint; RX_INT_OUT |-> RX_DMA_REQ_OUT; endproperty
  a_rxint: assert property (p_rxint) else $error("rx irq below level");
  property p_rts; RTS_N_OUT |-> RX_DMA_REQ_OUT; endproperty
  a_rts: assert property (p_rts) else $error("rts below level");
  property p_rdata; !RD_IN |=> $stable(RDATA_OUT); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_txfull; $fell(TX_DMA_REQ_OUT) |-> $past(WR_IN) || $past(WR_IN, 2) || $past(WR_IN, 3); endproperty
  a_txfull: assert property (p_txfull) else $error("tx full without write");
  property p_rxdrop; $fell(RX_DMA_REQ_OUT) |-> acc_age < 6'h04; endproperty
  a_rxdrop: assert property (p_rxdrop) else $error("rx request dropped alone");
endmodule // ast_uart_props
bind ast_uart ast_uart_props #(.DEPTH(DEPTH)) ast_uart_props_inst (
  .REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
  .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .RXD_IN(RXD_IN), .TXD_OUT(TXD_OUT), .CTS_N_IN(CTS_N_IN),
  .RTS_N_OUT(RTS_N_OUT), .RX_DMA_REQ_OUT(RX_DMA_REQ_OUT), .TX_DMA_REQ_OUT(TX_DMA_REQ_OUT),
  .RX_INT_OUT(RX_INT_OUT), .TX_INT_OUT(TX_INT_OUT));

//--- verification/ast_peer.sv
// far-end serial peripheral, eight data bits, no parity, one stop
`timescale 1ns/1ns
module ast_peer (
  input  wire logic        clk_in,
  input  wire logic        txd_in,
  input  wire logic        rts_n_in,
  input  wire logic [15:0] bitc_in,
  output logic             rxd_out,
  output logic             cts_n_out,
  output logic             got_out,
  output logic [7:0]       byte_out
);
  int         got_cnt;
  logic [7:0] sh;
  initial begin
    rxd_out = 1'b1;
    cts_n_out = 1'b0;
    got_out = 1'b0;
    byte_out = 8'h00;
  end
  task automatic send_char(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    while (rts_n_in) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (bitc_in) @(posedge clk_in);
    end
  endtask
  task automatic low_for(input int n);
    rxd_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    rxd_out <= 1'b1;
  endtask
  always begin
    @(negedge txd_in);
    repeat (bitc_in / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (bitc_in) @(posedge clk_in);
      sh[i] = txd_in;
    end
    repeat (bitc_in) @(posedge clk_in);
    byte_out <= sh;
    got_out <= 1'b1;
    @(posedge clk_in);
    got_out <= 1'b0;
    got_cnt++;
  end
endmodule // ast_peer

//--- verification/ast_uart_test.sv
// self-checking bench for the serial transceiver
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module ast_uart_test
  import ast_pkg::*;
;
  logic        clk, nrst, wr, rd, rd_d, txd, rxd, cts_n, rts_n, rxdma, txdma, rxint, txint, got;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, bitc, rq[$];
  logic [7:0]  d, gbyte, tq[$], bq[16];
  int          err_total, tests_run, dv;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ast_uart #(.DEPTH(16)) ast_uart_inst (.REF_CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RXD_IN(rxd), .TXD_OUT(txd), .CTS_N_IN(cts_n),
    .RTS_N_OUT(rts_n), .RX_DMA_REQ_OUT(rxdma), .TX_DMA_REQ_OUT(txdma), .RX_INT_OUT(rxint), .TX_INT_OUT(txint));
  ast_peer ast_peer_inst (.clk_in(clk), .txd_in(txd), .rts_n_in(rts_n), .bitc_in(bitc),
    .rxd_out(rxd), .cts_n_out(cts_n), .got_out(got), .byte_out(gbyte));
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_d) `CHK(rdata, rq.pop_front())
    if (got) `CHK(gbyte, tq.pop_front())
    rd_d <= rd;
  end
  initial begin
    idle(80000);
    err_total++;
    tally_and_finish();
  end
  initial begin
    {nrst, wr, rd, rd_d} = 4'h0;
    addr = 5'h00;
    wdata = 16'h0000;
    bitc = 16'h0010;
    void'($urandom(32'h60EE));
    idle(3);
    nrst <= 1'b1;
    rd_reg(ADDR_CTRL, {2'h0, CTRL_RST});
    rd_reg(ADDR_DIV, DIV_RST);
    rd_reg(5'h1C, 16'h0000);
    dv = 2 + $urandom % 3;
    bitc = 16'(16 * dv);
    wr_reg(ADDR_DIV, 16'(dv));
    rd_reg(ADDR_DIV, 16'(dv));
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      tq.push_back(d);
      wr_reg(ADDR_DATA, {8'h00, d});
    end
    idle(24 * bitc);
    tq.push_back(8'h00);
    wr_reg(ADDR_CTRL, 16'h0243);
    idle(12 * bitc);
    `CHK(txd, 1'b0)
    wr_reg(ADDR_CTRL, 16'h0043);
    idle(2 * bitc);
    ast_peer_inst.cts_n_out <= 1'b1;
    wr_reg(ADDR_CTRL, 16'h2843);
    for (int i = 0; i < 17; i++) begin
      d = 8'($urandom);
      if (i < 16) tq.push_back(d);
      wr_reg(ADDR_DATA, {8'h00, d});
    end
    idle(4 * bitc);
    `CHK({txd, txdma, txint}, 3'b100)
    ast_peer_inst.cts_n_out <= 1'b0;
    idle(170 * bitc);
    `CHK(ast_peer_inst.got_cnt, 19)
    `CHK({txdma, txint}, 2'b11)
    wr_reg(ADDR_CTRL, 16'h0043);
    d = 8'($urandom);
    ast_peer_inst.send_char(d);
    idle(bitc);
    rd_reg(ADDR_DATA, {8'h00, d});
    ast_peer_inst.low_for(3 * dv);
    idle(2 * bitc);
    rd_reg(ADDR_STAT, 16'h0042);
    ast_peer_inst.low_for(12 * bitc);
    idle(2 * bitc);
    rd_reg(ADDR_STAT, 16'h0073);
    rd_reg(ADDR_DATA, 16'h0000);
    wr_reg(ADDR_FORCE, 16'h000F);
    rd_reg(ADDR_STAT, 16'h007E);
    rd_reg(ADDR_STAT, 16'h0042);
    for (int i = 0; i < 9; i++) begin
      wr_reg(ADDR_CTRL, 16'h0440 | 16'(i % 4) | 16'((i % 3 != 0) << 2) | 16'((i % 3 == 2) << 3)
        | 16'((i / 3) << 4));
      d = 8'($urandom);
      wr_reg(ADDR_DATA, {8'h00, d});
      idle(14 * bitc);
      rd_reg(ADDR_DATA, {8'h00, d & (8'hFF >> (3 - i % 4))});
      rd_reg(ADDR_STAT, 16'h0042);
    end
    wr_reg(ADDR_CTRL, 16'h15C3);
    for (int i = 0; i < 17; i++) begin
      d = 8'($urandom);
      if (i < 16) bq[i] = d;
      wr_reg(ADDR_DATA, {8'h00, d});
      idle(11 * bitc);
      if (i == 12) `CHK({rxdma, rxint}, 2'b00)
      if (i == 13) `CHK({rxdma, rxint}, 2'b11)
    end
    wr_reg(ADDR_CTRL, 16'h1DC3);
    idle(2);
    `CHK(rts_n, 1'b1)
    rd_reg(ADDR_STAT, 16'h0047);
    for (int i = 0; i < 16; i++) rd_reg(ADDR_DATA, {8'h00, bq[i]});
    rd_reg(ADDR_STAT, 16'h0042);
    idle(2);
    `CHK(rts_n, 1'b0)
    tally_and_finish();
  end
endmodule // ast_uart_test
